// [drive_model.sv]
/* Behavioural drive: spins the index hole and holds media ident levels.
   Assumes the controller's pin enables are high while it drives. */
module drive_model #(
   parameter int IDX_PERIOD = 64
) (
   input  wire logic       pclk,
   input  wire logic [1:0] media_id,
   input  wire logic [1:0] pin_o,
   input  wire logic [1:0] pin_oe,
   output wire logic       index_pulse_n,
   output wire logic [1:0] pin_lvl
);
   int cnt_ff;
   // Spindle turns regardless of reset, so the hole passes at any time
   always @(posedge pclk) begin
      cnt_ff <= (cnt_ff + 1) % IDX_PERIOD;
   end
   assign index_pulse_n = cnt_ff >= 4;
   // Released pins show the drive's media code, never a stale level
   assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & media_id);
endmodule

// [fdd_assertions.sv]
/* Checker for the drive pin block, bound to its top module.
   Assumes writes that steer the pins go to mapped offsets only. */
`include "fdd_pins_consts.vh"
module fdd_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        write_protect_n,
   input wire logic        track_zero_n,
   input wire logic        index_pulse_n,
   input wire logic        density_select_out,
   input wire logic        rate_out_bit0,
   input wire logic        rate_out_bit0_oe,
   input wire logic        rate_out_bit1,
   input wire logic        rate_out_bit1_oe,
   input wire logic        write_start,
   input wire logic        head_at_track0,
   input wire logic        index_seen
);
   logic [1:0] rate_ff;
   logic       pol_ff, mode2_ff, armed_ff;
   wire        wr = psel & penable & pready & pwrite;
   wire        oe_any = rate_out_bit0_oe | rate_out_bit1_oe;
   wire [1:0]  rate_pins = {rate_out_bit1, rate_out_bit0};
   wire        exp_dens = pol_ff ~^ (rate_ff == `RATE_500K || rate_ff == `RATE_1M);
   // Shadow copy of the steering registers, updated on the same edge as the design
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_ff            <= `DATA_RATE_RESET;
         {mode2_ff, pol_ff} <= `CONFIG3_RESET;
         armed_ff           <= 1'b0;
      end else if (wr && paddr == `OFS_DATA_RATE) begin
         rate_ff  <= pwdata[1:0];
         armed_ff <= 1'b1;
      end else if (wr && paddr == `OFS_CONFIG3) begin
         {mode2_ff, pol_ff} <= pwdata[1:0];
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_cmd;
      wr && paddr == `OFS_WRITE_CMD && pwdata[`WCMD_GO];
   endsequence
   // Two samples low, so a synchronised refusal is covered too
   sequence s_wp_low;
      !write_protect_n [*2];
   endsequence
   a_track_zero_flag: assert property (1 |=> head_at_track0 == !$past(track_zero_n))
      else $error("track zero flag wrong");
   a_index_seen_set: assert property ($fell(index_pulse_n) |-> ##[1:2] index_seen)
      else $error("index not seen");
   a_write_blocked: assert property (s_wp_low |=> !write_start)
      else $error("write started while protected");
   a_write_taken: assert property (write_protect_n [*2] ##0 s_cmd |=> write_start)
      else $error("write not started");
   a_rate_value: assert property (rate_out_bit0_oe |-> rate_pins == $past(rate_ff))
      else $error("rate pins wrong");
   a_rate_float: assert property (!armed_ff |=> !oe_any)
      else $error("rate pins driven early");
   a_mode2_release: assert property (mode2_ff [*2] |-> !oe_any)
      else $error("rate pins driven in mode 2");
   a_density_level: assert property (1 |=> density_select_out == $past(exp_dens))
      else $error("density level wrong");
endmodule
bind fdd_status_rate_pins fdd_assertions fdd_assertions_inst (.*);

// [fdd_pins_consts.vh]
/*
 Constants for the floppy drive status and rate pin block: register offsets,
 field positions, reset values and rate codes.
 Assumes inclusion by bare name from the design files of this block.
*/
// What this block does
// - The density select output tells whether a low rate (250 or 300 kb/s) or a high rate (500 kb/s or 1 Mb/s) is chosen.
// - The level on the density select output follows the density polarity bit of configuration register 3.
// - While the write protect input is low every write command is ignored and no write reaches the medium.
// - A low track zero input means the head sits over the outermost track.
// - A low index input means the head is at the start of a track.
// - The two rate outputs carry bits 0 and 1 of the data rate register.
// - Both rate outputs stay undriven from power on until the data rate register drives them.
// - In enhanced floppy mode 2 the rate pins are media ident inputs read back as tape register bits 6 and 7.
`ifndef FDD_PINS_CONSTS_VH
`define FDD_PINS_CONSTS_VH

// Register byte offsets
`define OFS_DATA_RATE      8'h00
`define OFS_CONFIG3        8'h04
`define OFS_TAPE           8'h08
`define OFS_DRIVE_STATUS   8'h0C
`define OFS_WRITE_CMD      8'h10

// Data rate register fields
`define RATE_LSB           0
`define RATE_MSB           1
`define RATE_500K          2'h0
`define RATE_300K          2'h1
`define RATE_250K          2'h2
`define RATE_1M            2'h3
`define DATA_RATE_RESET    2'h2

// Configuration register 3 fields
`define CFG3_DENS_POL      0
`define CFG3_ENH_MODE2     1
`define CONFIG3_RESET      2'h1

// Tape register fields
`define TAPE_SEL_LSB       0
`define TAPE_SEL_MSB       1
`define TAPE_MEDIA0        6
`define TAPE_MEDIA1        7
`define TAPE_RESET         2'h0

// Drive status register fields
`define STS_WPROT          0
`define STS_TRACK0         1
`define STS_INDEX          2
`define STS_INDEX_SEEN     3
`define STS_WRITE_REFUSED  4
`define STS_RATE_DRIVEN    5

// Write command register: writing 1 here requests a write to the medium
`define WCMD_GO            0

`endif

// [fdd_status_rate_pins.v]
/*
 Drive-side pin logic of a floppy controller: density select, two rate pins
 that double as media ident inputs, and write protect, track zero and index
 status, with an APB register slave.
 Assumes drive inputs are synchronous to pclk and that the rate pin wires are
 resolved outside from the pin output and enable pairs.
*/
`include "fdd_pins_consts.vh"

module fdd_status_rate_pins #(
   parameter RATE_PINS = 2
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        write_protect_n,
   input  wire        track_zero_n,
   input  wire        index_pulse_n,
   output reg         density_select_out,
   input  wire        rate_out_bit0_i,
   input  wire        rate_out_bit1_i,
   output wire        rate_out_bit0,
   output wire        rate_out_bit0_oe,
   output wire        rate_out_bit1,
   output wire        rate_out_bit1_oe,
   output reg         write_start,
   output reg         head_at_track0,
   output reg         index_seen
);

   reg  [1:0] data_rate_ff;
   reg  [1:0] config3_ff;
   reg  [1:0] tape_sel_ff;
   reg        rate_driven_ff;
   reg        index_prev_ff;
   reg        write_refused_ff;
   reg        wprot_ff;
   reg        track0_ff;
   reg        index_ff;

   wire       access;
   wire       wr_en;
   wire       rd_en;
   wire       addr_hit;
   wire       enh_mode2;
   wire       low_rate;
   wire       index_fall;
   wire       wcmd_req;
   wire [RATE_PINS-1:0] pin_in;
   wire [RATE_PINS-1:0] pin_out;
   wire [RATE_PINS-1:0] pin_oe;
   wire [RATE_PINS-1:0] media_q;

   reg  [31:0] nxt_prdata;
   reg         nxt_density;
   reg         nxt_index_seen;
   reg         nxt_write_refused;

   // One wait state: pready rises in the second access cycle
   assign access   = psel & penable;
   assign wr_en    = access & pready & pwrite;
   assign rd_en    = access & ~pready & ~pwrite;
   assign addr_hit = (paddr == `OFS_DATA_RATE) || (paddr == `OFS_CONFIG3) ||
                     (paddr == `OFS_TAPE) || (paddr == `OFS_DRIVE_STATUS) ||
                     (paddr == `OFS_WRITE_CMD);

   assign enh_mode2  = config3_ff[`CFG3_ENH_MODE2];
   assign low_rate   = (data_rate_ff == `RATE_300K) || (data_rate_ff == `RATE_250K);
   assign index_fall = index_prev_ff & ~index_pulse_n;
   assign wcmd_req   = wr_en & (paddr == `OFS_WRITE_CMD) & pwdata[`WCMD_GO];

   // APB handshake and error flag, both registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= access & ~pready;
         pslverr <= access & ~pready & ~addr_hit;
         if (rd_en) begin
            prdata <= nxt_prdata;
         end
      end
   end

   // Read mux; unmapped offsets read as zero
   always @* begin
      nxt_prdata = 32'h0000_0000;
      case (paddr)
         `OFS_DATA_RATE: begin
            nxt_prdata[`RATE_MSB:`RATE_LSB] = data_rate_ff;
         end
         `OFS_CONFIG3: begin
            nxt_prdata[1:0] = config3_ff;
         end
         `OFS_TAPE: begin
            nxt_prdata[`TAPE_SEL_MSB:`TAPE_SEL_LSB] = tape_sel_ff;
            // Pin levels only mean media ident while mode 2 has the drivers off
            nxt_prdata[`TAPE_MEDIA0] = enh_mode2 & media_q[0];
            nxt_prdata[`TAPE_MEDIA1] = enh_mode2 & media_q[1];
         end
         `OFS_DRIVE_STATUS: begin
            nxt_prdata[`STS_WPROT]         = wprot_ff;
            nxt_prdata[`STS_TRACK0]        = track0_ff;
            nxt_prdata[`STS_INDEX]         = index_ff;
            nxt_prdata[`STS_INDEX_SEEN]    = index_seen;
            nxt_prdata[`STS_WRITE_REFUSED] = write_refused_ff;
            nxt_prdata[`STS_RATE_DRIVEN]   = rate_driven_ff;
         end
         default: begin
            nxt_prdata = 32'h0000_0000;
         end
      endcase
   end

   // Software registers; a data rate write arms the rate pin drivers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_rate_ff   <= `DATA_RATE_RESET;
         config3_ff     <= `CONFIG3_RESET;
         tape_sel_ff    <= `TAPE_RESET;
         rate_driven_ff <= 1'b0;
      end else if (wr_en) begin
         case (paddr)
            `OFS_DATA_RATE: begin
               data_rate_ff   <= pwdata[`RATE_MSB:`RATE_LSB];
               rate_driven_ff <= 1'b1;
            end
            `OFS_CONFIG3: begin
               config3_ff <= pwdata[1:0];
            end
            `OFS_TAPE: begin
               tape_sel_ff <= pwdata[`TAPE_SEL_MSB:`TAPE_SEL_LSB];
            end
            default: begin
               rate_driven_ff <= rate_driven_ff;
            end
         endcase
      end
   end

   // Density level: polarity bit decides which level means high rate
   always @* begin
      if (config3_ff[`CFG3_DENS_POL]) begin
         nxt_density = ~low_rate;
      end else begin
         nxt_density = low_rate;
      end
   end

   // Sticky flags: a new event in the clearing cycle keeps the flag set
   always @* begin
      nxt_index_seen    = index_seen;
      nxt_write_refused = write_refused_ff;
      if (wr_en && paddr == `OFS_DRIVE_STATUS) begin
         if (pwdata[`STS_INDEX_SEEN]) begin
            nxt_index_seen = 1'b0;
         end
         if (pwdata[`STS_WRITE_REFUSED]) begin
            nxt_write_refused = 1'b0;
         end
      end
      if (index_fall) begin
         nxt_index_seen = 1'b1;
      end
      if (wcmd_req && !write_protect_n) begin
         nxt_write_refused = 1'b1;
      end
   end

   // Drive status capture, write gating and density output
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         index_prev_ff      <= 1'b1;
         wprot_ff           <= 1'b0;
         track0_ff          <= 1'b0;
         index_ff           <= 1'b0;
         head_at_track0     <= 1'b0;
         index_seen         <= 1'b0;
         write_refused_ff   <= 1'b0;
         write_start        <= 1'b0;
         density_select_out <= 1'b0;
      end else begin
         index_prev_ff      <= index_pulse_n;
         wprot_ff           <= ~write_protect_n;
         track0_ff          <= ~track_zero_n;
         index_ff           <= ~index_pulse_n;
         head_at_track0     <= ~track_zero_n;
         index_seen         <= nxt_index_seen;
         write_refused_ff   <= nxt_write_refused;
         // A protected disk never sees a write start
         write_start        <= wcmd_req & write_protect_n;
         density_select_out <= nxt_density;
      end
   end

   assign pin_in = {rate_out_bit1_i, rate_out_bit0_i};

   // Rate pins: driven from the data rate bits once armed, released in mode 2
   genvar g;
   generate
      for (g = 0; g < RATE_PINS; g = g + 1) begin : rate_pin
         pin_cell u_cell (
            .pclk     (pclk),
            .presetn  (presetn),
            .drive_val(data_rate_ff[g]),
            .drive_en (rate_driven_ff & ~enh_mode2),
            .pin_i    (pin_in[g]),
            .pin_o    (pin_out[g]),
            .pin_oe   (pin_oe[g]),
            .sample_q (media_q[g])
         );
      end
   endgenerate

   assign rate_out_bit0    = pin_out[0];
   assign rate_out_bit0_oe = pin_oe[0];
   assign rate_out_bit1    = pin_out[1];
   assign rate_out_bit1_oe = pin_oe[1];

endmodule

// [pin_cell.v]
/*
 One bidirectional pin cell: registered drive value, registered output enable
 and a registered sample of the pin level.
 Assumes the pin wire is resolved outside from pin_o and pin_oe.
*/
module pin_cell (
   input  wire pclk,
   input  wire presetn,
   input  wire drive_val,
   input  wire drive_en,
   input  wire pin_i,
   output reg  pin_o,
   output reg  pin_oe,
   output reg  sample_q
);

   // Enable resets low so the pin floats until told otherwise
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_o    <= 1'b0;
         pin_oe   <= 1'b0;
         sample_q <= 1'b0;
      end else begin
         pin_o    <= drive_val;
         pin_oe   <= drive_en;
         sample_q <= pin_i;
      end
   end

endmodule

// [tb_top.sv]
/* Self-checking bench for the drive pin block with an APB master.
   Assumes the drive model sits on the rate pins and index line. */
`include "fdd_pins_consts.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, write_protect_n, track_zero_n, rd_err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rd_data;
   logic [1:0]  media_id;
   wire  [31:0] prdata;
   wire         pready, pslverr, density_select_out, write_start, head_at_track0, index_seen;
   wire         index_pulse_n, rate_out_bit0, rate_out_bit0_oe, rate_out_bit1, rate_out_bit1_oe;
   wire         rate_out_bit0_i, rate_out_bit1_i;
   int          fails, check_count, cyc;
   fdd_status_rate_pins #(.RATE_PINS(2)) fdd_status_rate_pins_inst (.*);
   drive_model #(.IDX_PERIOD(64)) drive_model_inst (.pclk(pclk), .media_id(media_id),
      .pin_o({rate_out_bit1, rate_out_bit0}), .pin_oe({rate_out_bit1_oe, rate_out_bit0_oe}),
      .index_pulse_n(index_pulse_n), .pin_lvl({rate_out_bit1_i, rate_out_bit0_i}));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // A run still going after 20000 cycles ends as a failure
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         print_verdict();
      end
   end
   function automatic logic dens(input logic pol, input logic [1:0] r);
      return pol ~^ (r == `RATE_500K || r == `RATE_1M);
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // One APB transfer; request held until pready is seen high at an edge.
   // An idle edge comes first, so back-to-back calls never drive psel twice in one step.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (int n = 0; n < 50 && pready !== 1'b1; n++)
         @(posedge pclk);
      // A slave that never answers is a mismatch, not a silent carry-on
      if (pready !== 1'b1)
         fails++;
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_idx(input logic lvl);
      for (int n = 0; n < 200 && index_pulse_n !== lvl; n++)
         @(posedge pclk);
      if (index_pulse_n !== lvl)
         fails++;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {write_protect_n, track_zero_n, media_id} = 4'hF;
      void'($urandom(68));
      repeat (4) @(posedge pclk);
      check("oe in reset", {rate_out_bit1_oe, rate_out_bit0_oe}, 2'h0);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      check("density after reset", density_select_out, dens(1'b1, `DATA_RATE_RESET));
      apb(1'b0, `OFS_TAPE, 32'h0);
      check("media outside mode 2", rd_data, 32'h0);
      check("oe before rate write", {rate_out_bit1_oe, rate_out_bit0_oe}, 2'h0);
      apb(1'b0, 8'h14, 32'h0);
      check("unmapped error", rd_err, 1'b1);
      check("unmapped data", rd_data, 32'h0000_0000);
      // Every rate code under both polarities
      for (int p = 0; p < 2; p++) begin
         for (int r = 0; r < 4; r++) begin
            apb(1'b1, `OFS_CONFIG3, 32'(p));
            apb(1'b1, `OFS_DATA_RATE, 32'(r));
            repeat (2) @(posedge pclk);
            check("density", density_select_out, dens(p[0], r[1:0]));
            check("rate oe", {rate_out_bit1_oe, rate_out_bit0_oe}, 2'h3);
            check("rate pins", {rate_out_bit1_i, rate_out_bit0_i}, r[1:0]);
         end
      end
      for (int i = 0; i < 12; i++) begin
         {write_protect_n, track_zero_n} <= 2'($urandom);
         repeat (3) @(posedge pclk);
         check("track zero", head_at_track0, !track_zero_n);
         apb(1'b1, `OFS_WRITE_CMD, 32'h1);
         @(posedge pclk);
         check("write start", write_start, write_protect_n);
         apb(1'b0, `OFS_DRIVE_STATUS, 32'h0);
         check("write refused", rd_data[4], !write_protect_n);
         check("status bits", rd_data[1:0], {!track_zero_n, !write_protect_n});
         apb(1'b1, `OFS_DRIVE_STATUS, 32'h10);
      end
      wait_idx(1'b0);
      wait_idx(1'b1);
      apb(1'b1, `OFS_DRIVE_STATUS, 32'h8);
      @(posedge pclk);
      check("index cleared", index_seen, 1'b0);
      wait_idx(1'b0);
      repeat (3) @(posedge pclk);
      check("index seen", index_seen, 1'b1);
      media_id <= 2'($urandom);
      apb(1'b1, `OFS_CONFIG3, 32'h3);
      apb(1'b1, `OFS_DATA_RATE, 32'h1);
      apb(1'b1, `OFS_TAPE, 32'h3);
      apb(1'b0, `OFS_TAPE, 32'h0);
      check("media ident", rd_data, {24'h0, media_id, 6'h03});
      check("oe in mode 2", {rate_out_bit1_oe, rate_out_bit0_oe}, 2'h0);
      print_verdict();
   end
endmodule
